// ### rtl/power_monitor_pkg.sv
`default_nettype none
package power_monitor_pkg;

	// ----------------------------------------------------------------
	// Clock and bus
	// ----------------------------------------------------------------
	localparam int clock_hz = 50_000_000;
	localparam int hz_per_mhz = 1_000_000;
	localparam int default_cycles_per_us = clock_hz / hz_per_mhz;
	localparam int addr_width = 8;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] config_offset = 8'h00;
	localparam logic [7:0] shunt_cal_offset = 8'h04;
	localparam logic [7:0] shunt_voltage_offset = 8'h08;
	localparam logic [7:0] bus_voltage_offset = 8'h0c;
	localparam logic [7:0] die_temperature_offset = 8'h10;
	localparam logic [7:0] current_offset = 8'h14;
	localparam logic [7:0] power_offset = 8'h18;
	localparam logic [7:0] status_offset = 8'h1c;

	// ----------------------------------------------------------------
	// Control fields and reset values
	// ----------------------------------------------------------------
	localparam int range_bit = 0;
	localparam int conv_time_lsb = 1;
	localparam int avg_lsb = 4;
	localparam logic input_range_reset = 1'b0;
	localparam logic [2:0] conv_time_reset = 3'h5;
	localparam logic [2:0] avg_reset = 3'h0;
	localparam logic [15:0] shunt_cal_reset = 16'h0000;
	localparam int status_count_lsb = 16;

	// ----------------------------------------------------------------
	// Conversion timing and averaging
	// ----------------------------------------------------------------
	localparam int conv_time_us [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
	localparam int avg_shift [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
	localparam int max_avg_shift = 10;

	// ----------------------------------------------------------------
	// Result arithmetic
	// ----------------------------------------------------------------
	// 819.2e6 times 5 uV per step gives 4096, applied as a shift
	localparam int current_scale_shift = 12;
	// Power step is one fifth of current step, 64 times current step times bus step
	localparam int power_shift = 6;
	localparam logic [15:0] current_pos_limit = 16'h7fff;
	localparam logic [15:0] current_neg_limit = 16'h8000;
	localparam logic [23:0] power_limit = 24'hffffff;

endpackage : power_monitor_pkg
`default_nettype wire

// ### rtl/quotient_divider.sv
`timescale 1ns/1ns
`default_nettype none
module quotient_divider #(
	parameter int dividend_width = 29,
	parameter int divisor_width = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [dividend_width-1:0] dividend,
	input wire logic [divisor_width-1:0] divisor,
	output logic done,
	output logic [dividend_width-1:0] quotient
);
	localparam int count_width = $clog2(dividend_width + 1);

	if (dividend_width < 2 || divisor_width < 1) begin : bad_width
		$error("quotient_divider widths out of range");
	end

	typedef struct packed {
		logic busy;
		logic done;
		logic [count_width-1:0] count;
		logic [divisor_width:0] rem;
		logic [divisor_width-1:0] div;
		logic [dividend_width-1:0] quo;
	} div_state_type;

	div_state_type s;
	div_state_type next_s;
	logic [divisor_width:0] trial;
	logic fits;

	// ----------------------------------------------------------------
	// Restoring division, one quotient bit per cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		trial = {s.rem[divisor_width-1:0], s.quo[dividend_width-1]};
		fits = trial >= {1'b0, s.div};
		if (start && !s.busy) begin
			next_s.busy = 1'b1;
			next_s.count = count_width'(dividend_width);
			next_s.rem = '0;
			next_s.div = divisor;
			next_s.quo = dividend;
		end else if (s.busy) begin
			next_s.quo = {s.quo[dividend_width-2:0], fits};
			next_s.rem = fits ? trial - {1'b0, s.div} : trial;
			next_s.count = s.count - count_width'(1);
			if (s.count == count_width'(1)) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
	assign quotient = s.quo;

endmodule : quotient_divider
`default_nettype wire

// ### rtl/power_monitor_result_scaling.sv
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1 - Range select 0 gives 163.84 mV full scale, 1 gives 40.96 mV.
// R2 - Shunt step is 5 uV wide range, 1.25 uV narrow range.
// R3 - Bus result is unsigned, 3.125 mV per step, 0 to 85 V.
// R4 - Shunt and bus results are 16-bit words.
// R5 - Shunt result is signed two's complement for both current directions.
// R6 - Die temperature is signed 12 bits, 125 millidegrees per step.
// R7 - Each completed shunt result yields a new current from calibration.
// R8 - Zero calibration constant forces current result to zero.
// R9 - Current uses fixed internal scaling of 819.2 times ten to six.
// R10 - Host programs calibration four times larger in narrow range.
// R11 - One current step equals the host-chosen current step size.
// R12 - Power result is a 24-bit unsigned value.
// R13 - Conversion time selectable 50 to 4120 us in eight steps.
// R14 - New output every conversion time times averaging count.
// R15 - Results stay stable until averaged, current and power all complete.
module power_monitor_result_scaling
	import power_monitor_pkg::*;
#(
	parameter int cycles_per_us = power_monitor_pkg::default_cycles_per_us
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [power_monitor_pkg::addr_width-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [power_monitor_pkg::addr_width-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [15:0] adc_shunt,
	input wire logic [15:0] adc_bus,
	input wire logic [11:0] adc_temp,
	output logic input_range_select,
	output logic conversion_strobe,
	output logic result_update
);
	import power_monitor_pkg::*;

	localparam int acc_width = 16 + max_avg_shift;
	localparam int temp_acc_width = 12 + max_avg_shift;
	localparam int num_width = 17 + current_scale_shift;
	localparam int timer_width = 24;
	localparam int count_width = max_avg_shift + 1;

	if (cycles_per_us < 1 || conv_time_us[7] * cycles_per_us >= 2 ** timer_width) begin : bad_rate
		$error("cycles_per_us out of range");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_full;
		logic [addr_width-1:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic range_sel;
		logic [2:0] conv_sel;
		logic [2:0] avg_sel;
		logic [15:0] shunt_cal;
		logic [timer_width-1:0] timer;
		logic [count_width-1:0] sample_count;
		logic [acc_width-1:0] acc_shunt;
		logic [acc_width-1:0] acc_bus;
		logic [temp_acc_width-1:0] acc_temp;
		logic conv_strobe;
		logic computing;
		logic div_start;
		logic cal_zero;
		logic negative;
		logic [16:0] pend_mag;
		logic [15:0] pend_shunt;
		logic [15:0] pend_bus;
		logic [11:0] pend_temp;
		logic [15:0] shunt_result;
		logic [15:0] bus_result;
		logic [11:0] temp_result;
		logic [15:0] current_result;
		logic [23:0] power_result;
		logic update;
	} state_type;

	state_type s;
	state_type next_s;

	logic div_done;
	logic [num_width-1:0] div_quotient;
	logic [num_width-1:0] div_dividend;
	logic [timer_width-1:0] period;
	logic [count_width-1:0] avg_count;
	logic [count_width-1:0] count_plus;
	logic [acc_width-1:0] sum_shunt;
	logic [acc_width-1:0] sum_bus;
	logic [temp_acc_width-1:0] sum_temp;
	logic [15:0] avg_shunt;
	logic [15:0] cur;
	logic [16:0] cur_mag;
	logic [32:0] product;
	logic [32:0] scaled;
	logic [31:0] cfg_word;
	logic [31:0] merged;
	logic cfg_write;
	logic [31:0] rd_word;
	logic rd_ok;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	// ----------------------------------------------------------------
	// Divider for the current result
	// ----------------------------------------------------------------
	assign div_dividend = {s.pend_mag, current_scale_shift'(0)}; // [R9]

	quotient_divider #(
		.dividend_width(num_width),
		.divisor_width(16)
	) current_divider (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(s.div_start),
		.dividend(div_dividend),
		.divisor(s.shunt_cal),
		.done(div_done),
		.quotient(div_quotient)
	);

	always_comb begin
		next_s = s;
		next_s.conv_strobe = 1'b0;
		next_s.update = 1'b0;
		next_s.div_start = 1'b0;
		cfg_write = 1'b0;
		cfg_word = '0;
		cfg_word[range_bit] = s.range_sel;
		cfg_word[conv_time_lsb +: 3] = s.conv_sel;
		cfg_word[avg_lsb +: 3] = s.avg_sel;
		merged = '0;
		rd_word = '0;
		rd_ok = 1'b1;
		period = timer_width'(conv_time_us[s.conv_sel] * cycles_per_us); // [R13]
		avg_count = count_width'(1) << avg_shift[s.avg_sel];
		count_plus = s.sample_count + count_width'(1);
		sum_shunt = s.acc_shunt + {{max_avg_shift{adc_shunt[15]}}, adc_shunt}; // [R5]
		sum_bus = s.acc_bus + {max_avg_shift'(0), adc_bus}; // [R3]
		sum_temp = s.acc_temp + {{max_avg_shift{adc_temp[11]}}, adc_temp}; // [R6]
		avg_shunt = 16'($signed(sum_shunt) >>> avg_shift[s.avg_sel]);
		cur = '0;
		cur_mag = '0;
		product = '0;
		scaled = '0;

		// ------------------------------------------------------------
		// Write channel
		// ------------------------------------------------------------
		if (s.awready && awvalid) begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (s.wready && wvalid) begin
			next_s.w_full = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.aw_full && s.w_full && !s.bvalid) begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = resp_okay;
			case (s.aw_addr)
				config_offset: begin
					merged = merge(cfg_word, s.w_data, s.w_strb);
					next_s.range_sel = merged[range_bit]; // [R1]
					next_s.conv_sel = merged[conv_time_lsb +: 3];
					next_s.avg_sel = merged[avg_lsb +: 3];
					cfg_write = 1'b1;
				end
				shunt_cal_offset: begin
					merged = merge({16'h0000, s.shunt_cal}, s.w_data, s.w_strb);
					next_s.shunt_cal = merged[15:0];
				end
				shunt_voltage_offset, bus_voltage_offset, die_temperature_offset,
				current_offset, power_offset, status_offset: begin
					next_s.bresp = resp_okay;
				end
				default: begin
					next_s.bresp = resp_slverr;
				end
			endcase
		end else if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		next_s.awready = !next_s.aw_full && !next_s.bvalid;
		next_s.wready = !next_s.w_full && !next_s.bvalid;

		// ------------------------------------------------------------
		// Read channel
		// ------------------------------------------------------------
		case (araddr)
			config_offset: rd_word = cfg_word;
			shunt_cal_offset: rd_word = {16'h0000, s.shunt_cal};
			shunt_voltage_offset: rd_word = {16'h0000, s.shunt_result}; // [R4]
			bus_voltage_offset: rd_word = {16'h0000, s.bus_result}; // [R4]
			die_temperature_offset: rd_word = {20'h00000, s.temp_result}; // [R6]
			current_offset: rd_word = {16'h0000, s.current_result};
			power_offset: rd_word = {8'h00, s.power_result}; // [R12]
			status_offset: begin
				rd_word[0] = s.computing;
				rd_word[status_count_lsb +: count_width] = s.sample_count;
			end
			default: rd_ok = 1'b0;
		endcase
		if (s.arready && arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_word;
			next_s.rresp = rd_ok ? resp_okay : resp_slverr;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		next_s.arready = !next_s.rvalid;

		// ------------------------------------------------------------
		// Conversion timing and averaging
		// ------------------------------------------------------------
		if (cfg_write) begin
			next_s.timer = '0;
			next_s.sample_count = '0;
			next_s.acc_shunt = '0;
			next_s.acc_bus = '0;
			next_s.acc_temp = '0;
		end else if (s.timer >= period - timer_width'(1)) begin // [R13]
			next_s.timer = '0;
			next_s.conv_strobe = 1'b1;
			if (count_plus == avg_count) begin // [R14]
				next_s.sample_count = '0;
				next_s.acc_shunt = '0;
				next_s.acc_bus = '0;
				next_s.acc_temp = '0;
				next_s.pend_shunt = avg_shunt;
				next_s.pend_bus = 16'(sum_bus >> avg_shift[s.avg_sel]);
				next_s.pend_temp = 12'($signed(sum_temp) >>> avg_shift[s.avg_sel]);
				next_s.negative = avg_shunt[15];
				next_s.pend_mag = avg_shunt[15] ? 17'h00000 - {1'b1, avg_shunt}
					: {1'b0, avg_shunt};
				next_s.computing = 1'b1; // [R7]
				next_s.cal_zero = s.shunt_cal == 16'h0000; // [R8]
				next_s.div_start = s.shunt_cal != 16'h0000; // [R7]
			end else begin
				next_s.sample_count = count_plus;
				next_s.acc_shunt = sum_shunt;
				next_s.acc_bus = sum_bus;
				next_s.acc_temp = sum_temp;
			end
		end else begin
			next_s.timer = s.timer + timer_width'(1);
		end

		// ------------------------------------------------------------
		// Current and power, published together
		// ------------------------------------------------------------
		if (s.computing && (s.cal_zero || div_done)) begin
			if (s.cal_zero) begin
				cur = '0; // [R8]
			end else if (s.negative) begin
				if (div_quotient > num_width'({1'b0, current_neg_limit})) begin
					cur = current_neg_limit;
				end else begin
					cur = 16'(num_width'(0) - div_quotient); // [R11]
				end
			end else if (div_quotient > num_width'(current_pos_limit)) begin
				cur = current_pos_limit;
			end else begin
				cur = div_quotient[15:0]; // [R11]
			end
			cur_mag = cur[15] ? 17'h00000 - {1'b1, cur} : {1'b0, cur};
			product = {16'h0000, cur_mag} * {17'h00000, s.pend_bus};
			scaled = product >> power_shift;
			next_s.power_result = (|scaled[32:24]) ? power_limit : scaled[23:0]; // [R12]
			next_s.current_result = cur;
			next_s.shunt_result = s.pend_shunt; // [R15]
			next_s.bus_result = s.pend_bus; // [R15]
			next_s.temp_result = s.pend_temp; // [R15]
			next_s.computing = 1'b0;
			next_s.update = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.range_sel <= input_range_reset;
			s.conv_sel <= conv_time_reset;
			s.avg_sel <= avg_reset;
			s.shunt_cal <= shunt_cal_reset;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign input_range_select = s.range_sel; // [R1] [R2]
	assign conversion_strobe = s.conv_strobe;
	assign result_update = s.update;

endmodule : power_monitor_result_scaling
`default_nettype wire

// ### test/result_scaling_properties.sv
`timescale 1ns/1ns
`default_nettype none
module result_scaling_properties
	import power_monitor_pkg::*;
#(
	parameter int cycles_per_us = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awready,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic input_range_select,
	input wire logic conversion_strobe,
	input wire logic result_update
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_bresp_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
	property p_rdata_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");
	property p_write_busy;
		bvalid |-> !awready && !wready;
	endproperty
	a_write_busy: assert property (p_write_busy) else $error("write ready during response");
	property p_read_busy;
		rvalid |-> !arready;
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("read ready during response");
	property p_resp_code;
		rvalid |-> rresp == resp_okay || rresp == resp_slverr;
	endproperty
	a_resp_code: assert property (p_resp_code) else $error("illegal read response");
	property p_strobe_gap;
		conversion_strobe |=> (!conversion_strobe) [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
	property p_update_pulse;
		result_update |=> !result_update;
	endproperty
	a_update_pulse: assert property (p_update_pulse) else $error("update not a pulse");
	property p_range_write;
		$changed(input_range_select) |-> bvalid;
	endproperty
	a_range_write: assert property (p_range_write) else $error("range changed without write");
	c_write: cover property (bvalid && bready);
	c_update: cover property (result_update);
	c_narrow: cover property (input_range_select);
endmodule : result_scaling_properties

bind power_monitor_result_scaling result_scaling_properties #(
	.cycles_per_us(cycles_per_us)
) result_scaling_properties_i (.aclk, .aresetn, .awready, .wready, .bresp, .bvalid,
	.bready, .arready, .rdata, .rresp, .rvalid, .rready, .input_range_select,
	.conversion_strobe, .result_update);
`default_nettype wire

// ### test/axi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module axi_host_model
	import power_monitor_pkg::*;
(
	input wire logic aclk,
	output logic [power_monitor_pkg::addr_width-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [power_monitor_pkg::addr_width-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Released payload shows the inverse so stale values cannot match
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : read
endmodule : axi_host_model
`default_nettype wire

// ### test/power_monitor_result_scaling_tb.sv
`timescale 1ns/1ns
`default_nettype none
module power_monitor_result_scaling_tb;
	import power_monitor_pkg::*;
	localparam int cpu = 1;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [addr_width-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] adc_shunt, adc_bus;
	logic [11:0] adc_temp;
	logic input_range_select, conversion_strobe, result_update;
	int n_errors = 0;
	int cmp_count = 0;
	power_monitor_result_scaling #(.cycles_per_us(cpu)) power_monitor_result_scaling_i (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .adc_shunt, .adc_bus, .adc_temp, .input_range_select,
		.conversion_strobe, .result_update);
	axi_host_model axi_host_model_i (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_host_model_i.write(a, d, r);
		check({30'h0, r}, {30'h0, resp_okay});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_host_model_i.read(a, d, r);
		check(d, e);
		check({30'h0, r}, {30'h0, er});
	endtask : rd
	// Counts strobes seen until the next update
	task automatic wait_update(output int s);
		int n;
		n = 0;
		s = 0;
		do begin
			@(negedge aclk);
			n++;
			s += int'(conversion_strobe === 1'b1);
		end while (result_update !== 1'b1 && n < 20000);
		check({31'h0, result_update}, 32'h1);
	endtask : wait_update
	task automatic wait_strobe(output int g);
		g = 0;
		do begin
			@(negedge aclk);
			g++;
		end while (conversion_strobe !== 1'b1 && g < 20000);
	endtask : wait_strobe
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [1:0] r;
		rd(config_offset, 32'h0000000a, resp_okay);
		axi_host_model_i.write(8'h20, 32'h00000001, r);
		check({30'h0, r}, {30'h0, resp_slverr});
		rd(config_offset, 32'h0000000a, resp_okay);
		rd(shunt_cal_offset, 32'h0, resp_okay);
		rd(power_offset, 32'h0, resp_okay);
		rd(8'h20, 32'h0, resp_slverr);
		check({31'h0, input_range_select}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_formats;
		int s;
		@(posedge aclk);
		adc_shunt <= 16'hff00;
		adc_bus <= 16'h0100;
		adc_temp <= 12'hf80;
		wr(config_offset, 32'h0);
		wait_update(s);
		rd(shunt_voltage_offset, 32'h0000ff00, resp_okay);
		rd(bus_voltage_offset, 32'h00000100, resp_okay);
		rd(die_temperature_offset, 32'h00000f80, resp_okay);
		rd(current_offset, 32'h0, resp_okay);
		rd(power_offset, 32'h0, resp_okay);
		$display("test formats done");
	endtask : t_formats
	task automatic t_current;
		int s;
		wr(shunt_cal_offset, 32'h00001000);
		wait_update(s);
		wait_update(s);
		rd(current_offset, 32'h0000ff00, resp_okay);
		rd(power_offset, 32'h00000400, resp_okay);
		wr(config_offset, 32'h1);
		wr(shunt_cal_offset, 32'h00004000);
		wait_update(s);
		wait_update(s);
		check({31'h0, input_range_select}, 32'h1);
		rd(current_offset, 32'h0000ffc0, resp_okay);
		rd(power_offset, 32'h00000100, resp_okay);
		$display("test current done");
	endtask : t_current
	task automatic t_period;
		int g;
		int s;
		for (int c = 0; c < 8; c++) begin
			wr(config_offset, {28'h0, c[2:0], 1'b0});
			wait_strobe(g);
			wait_strobe(g);
			check(g, conv_time_us[c] * cpu);
		end
		wr(config_offset, 32'h00000010);
		wait_update(s);
		wait_update(s);
		check(s, 32'h4);
		// A new sample enters the average but must not show until it completes
		@(posedge aclk);
		adc_shunt <= 16'h0100;
		wait_strobe(g);
		rd(shunt_voltage_offset, 32'h0000ff00, resp_okay);
		wait_update(s);
		rd(shunt_voltage_offset, 32'h00000100, resp_okay);
		$display("test period done");
	endtask : t_period
	initial begin
		aresetn = 1'b0;
		adc_shunt = '0;
		adc_bus = '0;
		adc_temp = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_formats;
		t_current;
		t_period;
		report_and_stop;
	end
	initial begin
		#1_000_000;
		n_errors++;
		report_and_stop;
	end
endmodule : power_monitor_result_scaling_tb
`default_nettype wire
